// [rtl/eeprom_launch_and_boot_select.sv]
// top: eeprom control register, launch sequence, move steering, config byte
`timescale 1ns/1ps
module eeprom_launch_and_boot_select
    import eeprom_boot_pkg::*;
#(
    parameter int PROG_COUNT = PROG_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    input wire logic moveWrite,
    input wire logic moveRead,
    input wire logic [15:0] moveAddr,
    input wire logic [7:0] moveWdata,
    output logic [7:0] moveRdata,
    output logic moveToEeprom,
    output logic moveToRam,
    output logic moveRefused,
    output logic latchWrite,
    output logic [PAGE_AW-1:0] latchOffset,
    output logic [7:0] latchData,
    output logic [EE_AW-1:0] pageBase,
    input wire logic [7:0] eepromRdata,
    output logic programStart,
    output logic programBusy,
    input wire logic apiActive,
    input wire logic [15:0] codeAddr,
    output logic bootFlashSelect,
    input wire logic cfgRead,
    input wire logic cfgWrite,
    input wire logic [3:0] cfgWdata,
    output logic [3:0] cfgRdata,
    input wire logic parallelMode,
    input wire logic parallelWrite,
    input wire logic [3:0] parallelWdata,
    output logic [3:0] parallelRdata,
    input wire logic chipErase,
    input wire logic [7:0] userBootVector,
    input wire logic port1CondPin,
    output logic [15:0] startAddress,
    output logic standardMode,
    output logic [1:0] oscillatorRange,
    output logic userBootPresent
);
    launch_if link ();

    logic eepromSpaceMap;
    logic launchArmed;
    // nonvolatile byte: starts out erased and keeps its value across system reset
    logic [7:0] configByte = CONFIG_ERASED;
    logic pageValid;
    logic portSync1;
    logic portSync2;
    logic controlHit;

    function automatic logic in_boot_region(input logic [15:0] a);
        in_boot_region = (a >= BOOT_START) && (a <= BOOT_TOP);
    endfunction : in_boot_region

    assign controlHit = (sfrAddr == CONTROL_ADDR);
    assign programBusy = link.busy;

    // launch pair: first nibble arms when not busy, the next write fires on A, re-arms on 5, otherwise cancels
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            launchArmed <= 1'b0;
            link.start <= 1'b0;
        end else if (clkEn) begin
            link.start <= 1'b0;
            if (sfrWrite && controlHit) begin
                if (link.busy) begin
                    launchArmed <= 1'b0;
                end else if (launchArmed && sfrWdata[LAUNCH_HI:LAUNCH_LO] == LAUNCH_SECOND) begin
                    launchArmed <= 1'b0;
                    link.start <= 1'b1;
                end else begin
                    launchArmed <= (sfrWdata[LAUNCH_HI:LAUNCH_LO] == LAUNCH_FIRST);
                end
            end
        end
    end
    assign programStart = link.start;

    program_timer #(.PROG_COUNT(PROG_COUNT)) timer (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .link(link)
    );

    // map bit writable; busy bit owned by the timer only
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            eepromSpaceMap <= CONTROL_RESET[MAP_BIT];
        end else if (clkEn && sfrWrite && controlHit) begin
            eepromSpaceMap <= sfrWdata[MAP_BIT];
        end
    end

    // reserved and launch bits read as zero, a legal pick for undefined
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sfrRdata <= 8'h00;
        end else if (clkEn && sfrRead) begin
            sfrRdata <= 8'h00;
            if (controlHit) begin
                sfrRdata[MAP_BIT] <= eepromSpaceMap;
                sfrRdata[BUSY_BIT] <= link.busy;
            end
        end
    end

    // move steering
    always_comb begin
        moveToEeprom = eepromSpaceMap && (moveWrite || moveRead);
        moveToRam = !eepromSpaceMap && (moveWrite || moveRead);
        moveRefused = eepromSpaceMap && moveRead && link.busy;
    end

    // column latches: first page sticks until programming is launched
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pageValid <= 1'b0;
            pageBase <= '0;
            latchWrite <= 1'b0;
            latchOffset <= '0;
            latchData <= 8'h00;
        end else if (clkEn) begin
            latchWrite <= 1'b0;
            if (link.start) begin
                pageValid <= 1'b0;
            end else if (moveWrite && eepromSpaceMap && !link.busy) begin
                if (!pageValid) begin
                    pageValid <= 1'b1;
                    pageBase <= {moveAddr[EE_AW-1:PAGE_AW], {PAGE_AW{1'b0}}};
                    latchWrite <= 1'b1;
                end else if (moveAddr[EE_AW-1:PAGE_AW] == pageBase[EE_AW-1:PAGE_AW]) begin
                    latchWrite <= 1'b1;
                end
                latchOffset <= moveAddr[PAGE_AW-1:0];
                latchData <= moveWdata;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            moveRdata <= 8'h00;
        end else if (clkEn && moveRead && eepromSpaceMap && !link.busy) begin
            moveRdata <= eepromRdata;
        end
    end

    assign bootFlashSelect = apiActive && in_boot_region(codeAddr);

    // configuration byte: upper nibble by software, lower by parallel mode
    // no reset branch, otherwise the jump bit could never reach the next boot
    always_ff @(posedge ref_clk) begin
        if (clkEn) begin
            if (chipErase) begin
                configByte <= CONFIG_ERASED;
            end else begin
                if (cfgWrite) begin
                    configByte[7:4] <= cfgWdata;
                end
                if (parallelMode && parallelWrite) begin
                    configByte[3:0] <= parallelWdata;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfgRdata <= 4'h0;
            parallelRdata <= 4'h0;
        end else if (clkEn) begin
            if (cfgRead) begin
                cfgRdata <= configByte[7:4];
            end
            parallelRdata <= parallelMode ? configByte[3:0] : 4'h0;
        end
    end

    // pin condition synchronised before boot selection samples it
    // kept out of reset so the level held during reset reaches the capture
    always_ff @(posedge ref_clk) begin
        if (clkEn) begin
            portSync1 <= port1CondPin;
            portSync2 <= portSync1;
        end
    end

    boot_select boot (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .configByte(configByte),
        .userBootVector(userBootVector),
        .portCondition(portSync2),
        .startAddress(startAddress),
        .standardMode(standardMode),
        .oscillatorRange(oscillatorRange),
        .userBootPresent(userBootPresent)
    );
endmodule : eeprom_launch_and_boot_select

// [rtl/eeprom_boot_pkg.sv]
// constants and types shared by the eeprom launch and boot select block
// How it works
// - launch only on upper nibble 5 then A
// - map bit set steers moves to EEPROM
// - map bit clear steers moves to expanded RAM
// - busy flag set while programming runs
// - busy flag cleared when programming ends
// - software writes never touch busy flag
// - reserved bits read undefined, never write one
// - reset clears map and busy bits
// - jump bit set starts application at zero
// - jump bit clear starts at bootloader entry
// - clock mode bit picks standard or double
// - oscillator range code selects frequency range
// - software reaches only upper configuration nibble
// - lock nibble reachable only in parallel mode
// - chip erase sets configuration byte to ones
// - boot vector all ones means none present
// - boot flash mapped top region during routines
// - port1 condition at reset forces bootloader
// - reads of EEPROM refused while busy
// - column latches keep first page only
package eeprom_boot_pkg;
    localparam logic [7:0] CONTROL_ADDR = 8'hD2;
    localparam int LAUNCH_HI = 7;
    localparam int LAUNCH_LO = 4;
    localparam int MAP_BIT = 1;
    localparam int BUSY_BIT = 0;
    localparam logic [3:0] LAUNCH_FIRST = 4'h5;
    localparam logic [3:0] LAUNCH_SECOND = 4'hA;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam int CLOCK_MODE_POS = 7;
    localparam int JUMP_POS = 6;
    localparam int OSC_HI = 5;
    localparam int OSC_LO = 4;
    localparam logic [7:0] CONFIG_ERASED = 8'hFF;
    localparam logic [7:0] VECTOR_ERASED = 8'hFF;
    localparam logic [1:0] OSC_16MHZ = 2'h2;
    localparam logic [1:0] OSC_8MHZ = 2'h1;
    localparam logic [15:0] APP_START = 16'h0000;
    localparam logic [15:0] BOOT_START = 16'hF400;
    localparam logic [15:0] BOOT_TOP = 16'hFFFF;
    localparam int PAGE_BYTES = 128;
    localparam int PAGE_AW = 7;
    localparam int EE_AW = 10;
    localparam real CLK_MHZ = 20.0;
    localparam real PROG_TIME_US = 100.0;
    localparam int PROG_CYCLES = int'($ceil(PROG_TIME_US * CLK_MHZ));
    localparam int CNT_W = 16;
endpackage : eeprom_boot_pkg

// [rtl/launch_if.sv]
// launch request and busy status between control and programming timer
`timescale 1ns/1ps
interface launch_if;
    logic start;
    logic busy;
    modport ctrl (output start, input busy);
    modport timer (input start, output busy);
endinterface : launch_if

// [rtl/program_timer.sv]
// programming timer that holds busy for the programming time
`timescale 1ns/1ps
module program_timer
    import eeprom_boot_pkg::*;
#(
    parameter int PROG_COUNT = PROG_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    launch_if.timer link
);
    logic [CNT_W-1:0] count;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link.busy <= 1'b0;
            count <= '0;
        end else if (clkEn) begin
            if (!link.busy && link.start) begin
                link.busy <= 1'b1;
                count <= CNT_W'(PROG_COUNT - 1);
            end else if (link.busy) begin
                if (count == '0) begin
                    link.busy <= 1'b0;
                end else begin
                    count <= count - 1'b1;
                end
            end
        end
    end
endmodule : program_timer

// [rtl/boot_select.sv]
// reset-time boot address and mode selection from the configuration byte
`timescale 1ns/1ps
module boot_select
    import eeprom_boot_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [7:0] configByte,
    input wire logic [7:0] userBootVector,
    input wire logic portCondition,
    output logic [15:0] startAddress,
    output logic standardMode,
    output logic [1:0] oscillatorRange,
    output logic userBootPresent
);
    logic captured;
    // caught once after reset release, not under the reset itself
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            captured <= 1'b0;
            startAddress <= BOOT_START;
            standardMode <= 1'b1;
            oscillatorRange <= OSC_16MHZ;
            userBootPresent <= 1'b0;
        end else if (clkEn && !captured) begin
            captured <= 1'b1;
            if (portCondition) begin
                startAddress <= BOOT_START;
            end else if (configByte[JUMP_POS]) begin
                startAddress <= APP_START;
            end else begin
                startAddress <= BOOT_START;
            end
            standardMode <= configByte[CLOCK_MODE_POS];
            oscillatorRange <= configByte[OSC_HI:OSC_LO];
            userBootPresent <= (userBootVector != VECTOR_ERASED);
        end
    end
endmodule : boot_select

// [verif/eeprom_array_model.sv]
// eeprom array seen from the move read data input
`timescale 1ns/1ps
module eeprom_array_model (
    input wire logic ref_clk,
    input wire logic moveRead,
    input wire logic [15:0] moveAddr,
    output logic [7:0] eepromRdata
);
    logic [7:0] junk = 8'h00;
    // outside a read the bus churns so a stale capture cannot pass
    always @(posedge ref_clk) junk <= junk + 8'h3B;
    assign eepromRdata = moveRead ? ~moveAddr[7:0] : junk;
endmodule : eeprom_array_model

// [verif/eeprom_launch_and_boot_select_chk.sv]
// assertions on the eeprom launch and boot select ports
`timescale 1ns/1ps
module eeprom_launch_and_boot_select_chk
    import eeprom_boot_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWdata,
    input wire logic [7:0] sfrRdata,
    input wire logic moveWrite,
    input wire logic moveRead,
    input wire logic moveToEeprom,
    input wire logic moveToRam,
    input wire logic moveRefused,
    input wire logic latchWrite,
    input wire logic programStart,
    input wire logic programBusy,
    input wire logic apiActive,
    input wire logic [15:0] codeAddr,
    input wire logic bootFlashSelect
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    launch_pair_a: assert property (
        programStart |-> $past(clkEn && sfrWrite && sfrAddr == CONTROL_ADDR && sfrWdata[7:4] == LAUNCH_SECOND))
        else $error("start without second launch write");
    start_pulse_a: assert property (programStart |=> !programStart)
        else $error("start longer than one cycle");
    busy_follow_a: assert property (programStart |=> programBusy)
        else $error("busy missing after start");
    busy_cause_a: assert property ($rose(programBusy) |-> $past(programStart))
        else $error("busy rose without start");
    idle_launch_a: assert property (programStart |-> !$past(programBusy))
        else $error("launch taken while busy");
    busy_read_a: assert property (
        $past(clkEn && sfrRead && sfrAddr == CONTROL_ADDR) |-> sfrRdata[BUSY_BIT] == $past(programBusy))
        else $error("busy bit read wrong");
    rsvd_read_a: assert property (
        $past(clkEn && sfrRead && sfrAddr == CONTROL_ADDR) |-> sfrRdata[7:2] == 6'h00)
        else $error("upper control bits not zero");
    steer_one_a: assert property ((moveWrite || moveRead) |-> moveToEeprom != moveToRam)
        else $error("move steering not exclusive");
    refuse_busy_a: assert property (moveRefused |-> moveRead && programBusy)
        else $error("refusal outside busy read");
    latch_cause_a: assert property (
        latchWrite |-> $past(clkEn && moveWrite && moveToEeprom && !programBusy))
        else $error("latch write without eeprom move");
    boot_map_a: assert property (bootFlashSelect == (apiActive && codeAddr >= BOOT_START))
        else $error("boot flash select wrong");
    cover property (programStart);
    cover property (moveRefused);
    cover property (latchWrite);
endmodule : eeprom_launch_and_boot_select_chk
bind eeprom_launch_and_boot_select eeprom_launch_and_boot_select_chk i_eeprom_launch_and_boot_select_chk (.*);

// [verif/eeprom_launch_and_boot_select_tb.sv]
// register level bench for the eeprom launch and boot select block
`timescale 1ns/1ps
module eeprom_launch_and_boot_select_tb;
    import eeprom_boot_pkg::*;
    logic ref_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, sfrWrite = 1'b0, sfrRead = 1'b0, moveWrite = 1'b0;
    logic moveRead = 1'b0, apiActive = 1'b0, cfgRead = 1'b0, cfgWrite = 1'b0, parallelMode = 1'b0;
    logic parallelWrite = 1'b0, chipErase = 1'b0, port1CondPin = 1'b0;
    logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, moveWdata = 8'h00, userBootVector = 8'hFF;
    logic [15:0] moveAddr = 16'h0000, codeAddr = 16'h0000;
    logic [3:0] cfgWdata = 4'h0, parallelWdata = 4'h0;
    logic [7:0] sfrRdata, moveRdata, latchData, eepromRdata, saved;
    logic [15:0] startAddress;
    logic [PAGE_AW-1:0] latchOffset;
    logic [EE_AW-1:0] pageBase;
    logic [3:0] cfgRdata, parallelRdata;
    logic [1:0] oscillatorRange;
    logic moveToEeprom, moveToRam, moveRefused, latchWrite, programStart, programBusy, bootFlashSelect;
    logic standardMode, userBootPresent, tE, tR, tF, tL;
    int failures = 0, check_count = 0, n;
    eeprom_launch_and_boot_select #(.PROG_COUNT(40)) i_eeprom_launch_and_boot_select (.*);
    eeprom_array_model i_eeprom_array_model (.*);
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task stop_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    task sfr_wr(input logic [7:0] d);
        @(posedge ref_clk);
        sfrWrite <= 1'b1;
        sfrAddr <= CONTROL_ADDR;
        sfrWdata <= d;
        @(posedge ref_clk);
        sfrWrite <= 1'b0;
        #1;
    endtask : sfr_wr
    task sfr_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        sfrRead <= 1'b1;
        sfrAddr <= a;
        @(posedge ref_clk);
        sfrRead <= 1'b0;
        #1;
        check(sfrRdata, exp);
    endtask : sfr_rd
    task mv(input logic w, input logic [15:0] a);
        @(posedge ref_clk);
        moveWrite <= w;
        moveRead <= !w;
        moveAddr <= a;
        moveWdata <= a[7:0];
        #1;
        tE = moveToEeprom;
        tR = moveToRam;
        tF = moveRefused;
        @(posedge ref_clk);
        moveWrite <= 1'b0;
        moveRead <= 1'b0;
        #1;
        tL = latchWrite;
    endtask : mv
    task step;
        @(posedge ref_clk);
    endtask : step
    task reboot(input logic [3:0] cfg, input logic pin);
        @(posedge ref_clk);
        cfgWrite <= 1'b1;
        cfgWdata <= cfg;
        port1CondPin <= pin;
        @(posedge ref_clk);
        cfgWrite <= 1'b0;
        sys_rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : reboot
    initial begin
        repeat (5) step();
        sys_rst <= 1'b0;
        repeat (2) step();
        #1;
        check(startAddress, APP_START);
        check(standardMode, 1'b1);
        check(oscillatorRange, 2'h3);
        check(userBootPresent, 1'b0);
        sfr_rd(CONTROL_ADDR, 8'h00);
        sfr_wr(8'h01);
        sfr_rd(CONTROL_ADDR, 8'h00);
        sfr_wr(8'h02);
        sfr_rd(8'h00, 8'h00);
        sfr_rd(CONTROL_ADDR, 8'h02);
        mv(1'b1, 16'h0103);
        check(tE, 1'b1);
        check({tL, latchOffset, latchData}, {1'b1, 7'h03, 8'h03});
        check(pageBase, 10'h100);
        mv(1'b1, 16'h0203);
        check(tL, 1'b0);
        mv(1'b0, 16'h0011);
        check(moveRdata, 8'hEE);
        saved = moveRdata;
        sfr_wr(8'h00);
        mv(1'b1, 16'h0005);
        check({tR, tE, tL}, 3'b100);
        sfr_wr(8'h02);
        sfr_wr(8'h52);
        sfr_wr(8'h02);
        sfr_wr(8'hA2);
        check(programStart, 1'b0);
        sfr_wr(8'h52);
        sfr_wr(8'hA2);
        check(programStart, 1'b1);
        step();
        #1;
        check(programBusy, 1'b1);
        mv(1'b0, 16'h0022);
        check({tF, moveRdata}, {1'b1, saved});
        sfr_wr(8'h02);
        sfr_wr(8'h52);
        sfr_rd(CONTROL_ADDR, 8'h03);
        n = 0;
        while (programBusy === 1'b1 && n < 100) begin
            step();
            #1;
            n++;
        end
        check(n < 100, 1'b1);
        if (n >= 100) stop_test();
        sfr_wr(8'hA2);
        check(programStart, 1'b0);
        sfr_rd(CONTROL_ADDR, 8'h02);
        mv(1'b1, 16'h0203);
        check(tL, 1'b1);
        cfgWrite <= 1'b1;
        cfgWdata <= 4'h2;
        parallelWrite <= 1'b1;
        parallelWdata <= 4'h5;
        step();
        cfgWrite <= 1'b0;
        parallelWrite <= 1'b0;
        cfgRead <= 1'b1;
        parallelMode <= 1'b1;
        step();
        cfgRead <= 1'b0;
        repeat (2) step();
        #1;
        check({cfgRdata, parallelRdata}, 8'h2F);
        parallelWrite <= 1'b1;
        step();
        parallelWrite <= 1'b0;
        chipErase <= 1'b1;
        step();
        #1;
        check(parallelRdata, 4'h5);
        chipErase <= 1'b0;
        cfgRead <= 1'b1;
        repeat (3) step();
        #1;
        cfgRead <= 1'b0;
        check({cfgRdata, parallelRdata}, 8'hFF);
        apiActive <= 1'b1;
        codeAddr <= BOOT_START;
        step();
        #1;
        check(bootFlashSelect, 1'b1);
        codeAddr <= 16'hF3FF;
        step();
        #1;
        check(bootFlashSelect, 1'b0);
        reboot(4'h2, 1'b0);
        check(startAddress, BOOT_START);
        check(standardMode, 1'b0);
        check(oscillatorRange, 2'h2);
        userBootVector <= 8'h7C;
        reboot(4'hD, 1'b1);
        check(startAddress, BOOT_START);
        check(oscillatorRange, 2'h1);
        check(userBootPresent, 1'b1);
        sfr_rd(CONTROL_ADDR, 8'h00);
        stop_test();
    end
endmodule : eeprom_launch_and_boot_select_tb
